//--- design/msc_misc_pins.sv
// Miscellaneous pins: GPIO, straps, scan pin, EEPROM, debug, test port
`timescale 1ns/1ps
module msc_misc_pins (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Core side
  input  wire logic        smbus_used_i,
  input  wire logic [2:0]  port_state_i,
  output logic      [2:0]  smb_address_o,
  output logic      [4:0]  debug_select_o,
  output logic             debug_mode_o,
  output logic             power_save_o,
  // General-purpose pins
  input  wire logic [7:0]  gpio_i,
  output logic      [7:0]  gpio_o,
  output logic      [7:0]  gpio_oe_o,
  // Straps and debug pins
  input  wire logic        power_save_strap_i,
  input  wire logic        debug_mode_enable_pin_i,
  input  wire logic        status_output_enable_pin_i,
  input  wire logic        mfg_test_i,
  output logic      [2:0]  port_status_o,
  output logic             port_status_oe_o,
  // Full-scan control pin
  input  wire logic        scan_en_i,
  output logic             scan_en_o,
  output logic             scan_en_oe_o,
  // EEPROM pins
  output logic             eeprom_serial_clock_o,
  input  wire logic        eeprom_serial_io_i,
  output logic             eeprom_serial_io_o,
  output logic             eeprom_serial_io_oe_o,
  // Test access port pins
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  input  wire logic        trst_n_i,
  output logic             tdo_o,
  output logic             tdo_oe_o
);

  //------------------------------------------------------------------
  // State
  //------------------------------------------------------------------
  typedef struct packed {
    logic [msc_pkg::SY_W-1:0] s1;
    logic [msc_pkg::SY_W-1:0] s2;
    logic                     tck_d;
    logic [1:0]               settle;
    logic                     strap_done;
    logic                     pwr_save;
    logic                     dbg_mode;
    logic [7:0]               oe;
    logic [7:0]               goe;
    logic [7:0]               dout;
    logic [2:0]               smb;
    logic [4:0]               sel;
    logic [31:0]              rdata;
    logic [2:0]               pstat;
    logic                     pstat_oe;
    logic                     scan_oe;
    logic                     ee_busy;
    logic                     ee_rd;
    logic [7:0]               ee_sh;
    logic [2:0]               ee_bit;
    logic                     ee_high;
    logic [9:0]               ee_div;
    logic                     ee_clk;
    logic                     ee_io;
    logic                     ee_oe;
  } msc_st_type;

  msc_st_type r, n;

  logic [msc_pkg::SY_W-1:0] pins;
  logic                     tck_rise;
  logic                     tck_fall;
  logic                     ee_start;
  logic                     ee_tick;

  // Address match, used by the write path and the EEPROM start; reads decode with a case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  //------------------------------------------------------------------
  // Pin gathering and edge enables
  //------------------------------------------------------------------
  // All off-domain inputs enter one two-stage synchroniser
  assign pins = {mfg_test_i, trst_n_i, tdi_i, tms_i, tck_i,
                 eeprom_serial_io_i, scan_en_i, status_output_enable_pin_i,
                 debug_mode_enable_pin_i, power_save_strap_i, gpio_i};

  // Test clock is sampled, not used as a clock; edges become enables
  assign tck_rise = r.s2[msc_pkg::SY_TCK] && !r.tck_d;
  assign tck_fall = !r.s2[msc_pkg::SY_TCK] && r.tck_d;

  // Start is ignored while a byte is still in flight
  assign ee_start = reg_wr_i && hit(reg_addr_i, msc_pkg::ADDR_EE_CTRL) &&
                    reg_wdata_i[msc_pkg::EE_GO_BIT] && !r.ee_busy;
  assign ee_tick  = r.ee_busy && (r.ee_div == msc_pkg::EE_HALF_CNT);

  //------------------------------------------------------------------
  // Next-state logic
  //------------------------------------------------------------------
  always_comb begin
    n       = r;
    n.s1    = pins;
    n.s2    = r.s1;
    n.tck_d = r.s2[msc_pkg::SY_TCK];

    // Straps settle through the synchroniser, then are caught once
    if (!r.strap_done) begin
      if (r.settle == msc_pkg::STRAP_SETTLE) begin
        n.strap_done = 1'b1;                                    // RULE15
        n.pwr_save   = r.s2[msc_pkg::SY_PWR];                   // RULE4
        n.dbg_mode   = !r.s2[msc_pkg::SY_DBG];                  // RULE9
      end else begin
        n.settle = r.settle + 2'd1;
      end
    end

    // Pins 7..5 give the management address, 4..0 the debug selection
    n.smb = r.s2[7:msc_pkg::SMB_LSB];                           // RULE2
    n.sel = r.dbg_mode ? r.s2[4:0] : 5'h00;                     // RULE3

    // Direction from software, overridden where pins are inputs by role
    n.goe = r.oe;                                               // RULE1
    if (smbus_used_i) begin
      n.goe[7:msc_pkg::SMB_LSB] = 3'h0;                         // RULE2
    end
    if (r.dbg_mode) begin
      n.goe[4:0] = 5'h00;                                       // RULE3
    end

    // Port status reaches the header only in debug with enable pin
    n.pstat_oe = r.dbg_mode && r.s2[msc_pkg::SY_SOE];           // RULE8
    n.pstat    = n.pstat_oe ? port_state_i : 3'h0;              // RULE14

    // Scan pin is released only while manufacturing test is strapped
    n.scan_oe = !r.s2[msc_pkg::SY_MFG];                         // RULE5

    // Register writes
    if (reg_wr_i) begin
      if (hit(reg_addr_i, msc_pkg::ADDR_GPIO_OE)) begin
        n.oe = reg_wdata_i[7:0];                                // RULE1
      end
      if (hit(reg_addr_i, msc_pkg::ADDR_GPIO_OUT)) begin
        n.dout = reg_wdata_i[7:0];
      end
      if (hit(reg_addr_i, msc_pkg::ADDR_EE_DATA) && !r.ee_busy) begin
        n.ee_sh = reg_wdata_i[7:0];
      end
    end

    // Register reads: data stand one cycle, zero otherwise
    n.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        msc_pkg::ADDR_GPIO_OE:  n.rdata = {24'h00_0000, r.oe};
        msc_pkg::ADDR_GPIO_OUT: n.rdata = {24'h00_0000, r.dout};
        msc_pkg::ADDR_GPIO_IN:  n.rdata = {24'h00_0000, r.s2[7:0]};
        msc_pkg::ADDR_STRAP: begin
          n.rdata[msc_pkg::STRAP_PWR_BIT] = r.pwr_save;
          n.rdata[msc_pkg::STRAP_DBG_BIT] = r.dbg_mode;
          n.rdata[msc_pkg::STRAP_SMB_LSB +: 3] = r.smb;
          n.rdata[msc_pkg::STRAP_SEL_LSB +: 5] = r.sel;
        end
        msc_pkg::ADDR_EE_CTRL: begin
          n.rdata[msc_pkg::EE_RD_BIT]   = r.ee_rd;
          n.rdata[msc_pkg::EE_BUSY_BIT] = r.ee_busy;
        end
        msc_pkg::ADDR_EE_DATA:  n.rdata = {24'h00_0000, r.ee_sh};
        msc_pkg::ADDR_PSTAT:    n.rdata = {29'h0000_0000, port_state_i};
        default:                n.rdata = 32'h0000_0000;
      endcase
    end

    // EEPROM byte engine: data set while clock low, sampled at rise
    if (ee_start) begin
      n.ee_busy = 1'b1;                                         // RULE7
      n.ee_rd   = reg_wdata_i[msc_pkg::EE_RD_BIT];
      n.ee_bit  = 3'd7;
      n.ee_high = 1'b0;
      n.ee_div  = 10'h000;
      n.ee_clk  = 1'b0;
      n.ee_oe   = !reg_wdata_i[msc_pkg::EE_RD_BIT];
      n.ee_io   = reg_wdata_i[msc_pkg::EE_RD_BIT] ? 1'b1 : r.ee_sh[7];
    end else if (r.ee_busy) begin
      n.ee_div = ee_tick ? 10'h000 : r.ee_div + 10'h001;
      if (ee_tick && !r.ee_high) begin
        n.ee_clk  = 1'b1;                                       // RULE7
        n.ee_high = 1'b1;
        if (r.ee_rd) begin
          n.ee_sh = {r.ee_sh[6:0], r.s2[msc_pkg::SY_EEIO]};
        end
      end else if (ee_tick) begin
        n.ee_clk  = 1'b0;
        n.ee_high = 1'b0;
        if (r.ee_bit == 3'd0) begin
          n.ee_busy = 1'b0;
          n.ee_oe   = 1'b1;                                     // RULE6
          n.ee_io   = 1'b1;                                     // RULE6
        end else begin
          n.ee_bit = r.ee_bit - 3'd1;
          if (!r.ee_rd) begin
            n.ee_sh = {r.ee_sh[6:0], 1'b1};
            n.ee_io = r.ee_sh[6];
          end
        end
      end
    end
  end

  //------------------------------------------------------------------
  // State register
  //------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r          <= '0;
      r.oe       <= msc_pkg::GPIO_OE_RST;
      r.goe      <= msc_pkg::GPIO_OE_RST;
      r.dout     <= msc_pkg::GPIO_OUT_RST;
      r.ee_sh    <= msc_pkg::EE_DATA_RST;
      r.scan_oe  <= 1'b1;
      r.ee_io    <= 1'b1;
      r.ee_oe    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  //------------------------------------------------------------------
  // Test access port
  //------------------------------------------------------------------
  msc_tap u_tap (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .tck_rise_i (tck_rise),
    .tck_fall_i (tck_fall),
    .tms_i      (r.s2[msc_pkg::SY_TMS]),
    .tdi_i      (r.s2[msc_pkg::SY_TDI]),
    .trst_n_i   (r.s2[msc_pkg::SY_TRST]),
    .scan_en_i  (r.s2[msc_pkg::SY_SCAN]),
    .tdo_o      (tdo_o),
    .tdo_oe_o   (tdo_oe_o)
  );

  //------------------------------------------------------------------
  // Outputs, all straight from state flops except scan_en_o, tied low
  //------------------------------------------------------------------
  assign reg_rdata_o           = r.rdata;
  assign smb_address_o         = r.smb;
  assign debug_select_o        = r.sel;
  assign debug_mode_o          = r.dbg_mode;
  assign power_save_o          = r.pwr_save;
  assign gpio_o                = r.dout;
  assign gpio_oe_o             = r.goe;
  assign port_status_o         = r.pstat;
  assign port_status_oe_o      = r.pstat_oe;
  assign scan_en_o             = 1'b0;                          // RULE5
  assign scan_en_oe_o          = r.scan_oe;
  assign eeprom_serial_clock_o = r.ee_clk;
  assign eeprom_serial_io_o    = r.ee_io;
  assign eeprom_serial_io_oe_o = r.ee_oe;

  //------------------------------------------------------------------
  // Checks
  //------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_ee_go;
    ee_start;
  endsequence

  sequence s_ee_first_edge;
    !eeprom_serial_clock_o [*8] ##1 eeprom_serial_io_oe_o == !r.ee_rd;
  endsequence

  strap_catch_a: assert property ($rose(r.strap_done) |->
      power_save_o == $past(r.s2[msc_pkg::SY_PWR]) &&
      debug_mode_o == !$past(r.s2[msc_pkg::SY_DBG]))
    else $error("Straps not caught at release"); // RULE4
  strap_hold_a: assert property ($past(r.strap_done) |->
      $stable(power_save_o) && $stable(debug_mode_o))
    else $error("Strap changed after capture"); // RULE15
  gpio_dir_a: assert property (reg_wr_i &&
      hit(reg_addr_i, msc_pkg::ADDR_GPIO_OE) && !smbus_used_i &&
      !debug_mode_o ##1 !smbus_used_i |=> gpio_oe_o == $past(reg_wdata_i[7:0], 2))
    else $error("Direction register not applied"); // RULE1
  smb_input_a: assert property (smbus_used_i |=>
      gpio_oe_o[7:msc_pkg::SMB_LSB] == 3'h0)
    else $error("Address pins driven under management bus"); // RULE2
  dbg_sel_a: assert property (debug_mode_o |=>
      gpio_oe_o[4:0] == 5'h00 && debug_select_o == $past(r.s2[4:0]))
    else $error("Debug selection pins misused"); // RULE3
  pstat_gate_a: assert property (port_status_oe_o |->
      $past(debug_mode_o && r.s2[msc_pkg::SY_SOE]))
    else $error("Port status enabled outside debug"); // RULE8
  scan_drive_a: assert property (!r.s2[msc_pkg::SY_MFG] |=>
      scan_en_oe_o && !scan_en_o)
    else $error("Scan pin not driven low"); // RULE5
  ee_idle_a: assert property (!r.ee_busy |->
      eeprom_serial_io_o && eeprom_serial_io_oe_o && !eeprom_serial_clock_o)
    else $error("EEPROM data not resting high"); // RULE6
  ee_start_a: assert property (s_ee_go |=> r.ee_busy ##0 s_ee_first_edge)
    else $error("EEPROM transfer start wrong"); // RULE7

endmodule : msc_misc_pins

//--- shared/msc_pkg.sv
// Constants and types shared by the miscellaneous pin block
//--------------------------------------------------------------------
// Notes on behaviour
// RULE1 - Eight pins, direction set per register bit
// RULE2 - Management bus uses pins 7..5 as address
// RULE3 - Debug mode reads pins 4..0 as selection
// RULE4 - Power-save strap sampled at reset, high enables
// RULE5 - Scan pin driven low except manufacturing test
// RULE6 - EEPROM data pin rests at one
// RULE7 - Device masters EEPROM clock and data
// RULE8 - Port status driven only with enable pin
// RULE9 - Debug enable pin low means debug mode
// RULE10 - Test reset low forces TAP to reset
// RULE11 - TAP state follows mode select per clock
// RULE12 - Tester shifts data in while scan high
// RULE13 - Device shifts data out while scan high
// RULE14 - One status output for ports 0..2
// RULE15 - Straps latched at reset release, then held
//--------------------------------------------------------------------
package msc_pkg;

  // Clock and EEPROM serial clock rate
  localparam int         CLK_HZ      = 100_000_000;
  localparam int         EE_CLK_HZ   = 100_000;
  localparam int         EE_HALF_CYC = CLK_HZ / (2 * EE_CLK_HZ);
  localparam logic [9:0] EE_HALF_CNT = 10'(EE_HALF_CYC - 1);

  // Register byte addresses
  localparam logic [7:0] ADDR_GPIO_OE  = 8'h00;
  localparam logic [7:0] ADDR_GPIO_OUT = 8'h04;
  localparam logic [7:0] ADDR_GPIO_IN  = 8'h08;
  localparam logic [7:0] ADDR_STRAP    = 8'h0c;
  localparam logic [7:0] ADDR_EE_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_EE_DATA  = 8'h14;
  localparam logic [7:0] ADDR_PSTAT    = 8'h18;

  // Reset values
  localparam logic [7:0] GPIO_OE_RST  = 8'h00;
  localparam logic [7:0] GPIO_OUT_RST = 8'h00;
  localparam logic [7:0] EE_DATA_RST  = 8'hff;

  // Field positions
  localparam int SMB_LSB       = 5;
  localparam int STRAP_PWR_BIT = 0;
  localparam int STRAP_DBG_BIT = 1;
  localparam int STRAP_SMB_LSB = 4;
  localparam int STRAP_SEL_LSB = 8;
  localparam int EE_GO_BIT     = 0;
  localparam int EE_RD_BIT     = 1;
  localparam int EE_BUSY_BIT   = 2;

  // Synchroniser vector layout
  localparam int SY_PWR  = 8;
  localparam int SY_DBG  = 9;
  localparam int SY_SOE  = 10;
  localparam int SY_SCAN = 11;
  localparam int SY_EEIO = 12;
  localparam int SY_TCK  = 13;
  localparam int SY_TMS  = 14;
  localparam int SY_TDI  = 15;
  localparam int SY_TRST = 16;
  localparam int SY_MFG  = 17;
  localparam int SY_W    = 18;

  // Cycles after reset release until synchronised straps are valid
  localparam logic [1:0] STRAP_SETTLE = 2'd3;

  // Test access port
  localparam int         IR_W       = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  typedef enum logic [3:0] {
    TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3, TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5,
    TAP_PA_DR  = 4'h6, TAP_EX2_DR = 4'h7, TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR  = 4'hb,
    TAP_EX1_IR = 4'hc, TAP_PA_IR  = 4'hd, TAP_EX2_IR = 4'he,
    TAP_UPD_IR = 4'hf
  } msc_tap_state_type;

endpackage : msc_pkg

//--- design/msc_tap.sv
// Test access port controller with instruction and bypass registers
`timescale 1ns/1ps
module msc_tap (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Synchronised test pins and edge enables
  input  wire logic tck_rise_i,
  input  wire logic tck_fall_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  input  wire logic trst_n_i,
  input  wire logic scan_en_i,
  // Serial output
  output logic      tdo_o,
  output logic      tdo_oe_o
);

  typedef struct packed {
    msc_pkg::msc_tap_state_type st;
    logic [msc_pkg::IR_W-1:0]   ir;
    logic [msc_pkg::IR_W-1:0]   ir_act;
    logic                       byp;
    logic                       tdo;
    logic                       tdo_oe;
  } msc_tap_st_type;

  msc_tap_st_type r, n;

  // Standard TAP walk; one step per test clock rising edge
  function automatic msc_pkg::msc_tap_state_type tap_next(
    input msc_pkg::msc_tap_state_type s, input logic m);
    case (s)
      msc_pkg::TAP_RESET:  tap_next = m ? msc_pkg::TAP_RESET
                                        : msc_pkg::TAP_IDLE;
      msc_pkg::TAP_IDLE:   tap_next = m ? msc_pkg::TAP_SEL_DR
                                        : msc_pkg::TAP_IDLE;
      msc_pkg::TAP_SEL_DR: tap_next = m ? msc_pkg::TAP_SEL_IR
                                        : msc_pkg::TAP_CAP_DR;
      msc_pkg::TAP_CAP_DR,
      msc_pkg::TAP_SH_DR:  tap_next = m ? msc_pkg::TAP_EX1_DR
                                        : msc_pkg::TAP_SH_DR;
      msc_pkg::TAP_EX1_DR: tap_next = m ? msc_pkg::TAP_UPD_DR
                                        : msc_pkg::TAP_PA_DR;
      msc_pkg::TAP_PA_DR:  tap_next = m ? msc_pkg::TAP_EX2_DR
                                        : msc_pkg::TAP_PA_DR;
      msc_pkg::TAP_EX2_DR: tap_next = m ? msc_pkg::TAP_UPD_DR
                                        : msc_pkg::TAP_SH_DR;
      msc_pkg::TAP_SEL_IR: tap_next = m ? msc_pkg::TAP_RESET
                                        : msc_pkg::TAP_CAP_IR;
      msc_pkg::TAP_CAP_IR,
      msc_pkg::TAP_SH_IR:  tap_next = m ? msc_pkg::TAP_EX1_IR
                                        : msc_pkg::TAP_SH_IR;
      msc_pkg::TAP_EX1_IR: tap_next = m ? msc_pkg::TAP_UPD_IR
                                        : msc_pkg::TAP_PA_IR;
      msc_pkg::TAP_PA_IR:  tap_next = m ? msc_pkg::TAP_EX2_IR
                                        : msc_pkg::TAP_PA_IR;
      msc_pkg::TAP_EX2_IR: tap_next = m ? msc_pkg::TAP_UPD_IR
                                        : msc_pkg::TAP_SH_IR;
      msc_pkg::TAP_UPD_DR,
      msc_pkg::TAP_UPD_IR: tap_next = m ? msc_pkg::TAP_SEL_DR
                                        : msc_pkg::TAP_IDLE;
      default:             tap_next = msc_pkg::TAP_RESET;
    endcase
  endfunction : tap_next

  // Next state: reset, advance, capture, shift
  always_comb begin
    n = r;
    if (!trst_n_i) begin
      n.st     = msc_pkg::TAP_RESET; // RULE10
      n.ir_act = '1;
    end else if (tck_rise_i) begin
      n.st = tap_next(r.st, tms_i); // RULE11
      case (r.st)
        msc_pkg::TAP_CAP_IR: n.ir = msc_pkg::IR_CAPTURE;
        msc_pkg::TAP_CAP_DR: n.byp = 1'b0;
        msc_pkg::TAP_UPD_IR: n.ir_act = r.ir;
        msc_pkg::TAP_SH_IR: begin
          if (scan_en_i) begin
            n.ir = {tdi_i, r.ir[msc_pkg::IR_W-1:1]}; // RULE12
          end
        end
        msc_pkg::TAP_SH_DR: begin
          if (scan_en_i) begin
            n.byp = tdi_i; // RULE12
          end
        end
        default: n.byp = r.byp;
      endcase
    end
    // Output changes on the falling edge so the tester samples it stable
    if (tck_fall_i) begin
      n.tdo = (r.st == msc_pkg::TAP_SH_IR) ? r.ir[0] : r.byp; // RULE13
    end
    n.tdo_oe = scan_en_i && (r.st == msc_pkg::TAP_SH_IR ||
                             r.st == msc_pkg::TAP_SH_DR); // RULE13
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '{st: msc_pkg::TAP_RESET, ir: msc_pkg::IR_CAPTURE,
             ir_act: '1, byp: 1'b0, tdo: 1'b0, tdo_oe: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign tdo_o    = r.tdo;
  assign tdo_oe_o = r.tdo_oe;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  trst_force_a: assert property (!trst_n_i |=> r.st == msc_pkg::TAP_RESET)
    else $error("TAP not reset by test reset"); // RULE10
  tms_step_a: assert property (trst_n_i && tck_rise_i && tms_i &&
      r.st == msc_pkg::TAP_IDLE |=> r.st == msc_pkg::TAP_SEL_DR)
    else $error("TAP ignored mode select"); // RULE11
  ir_shift_a: assert property (trst_n_i && tck_rise_i && scan_en_i &&
      r.st == msc_pkg::TAP_SH_IR |=> r.ir[msc_pkg::IR_W-1] == $past(tdi_i))
    else $error("Instruction bit not shifted in"); // RULE12
  tdo_gate_a: assert property (tdo_oe_o |-> $past(scan_en_i))
    else $error("Test output driven without scan enable"); // RULE13

endmodule : msc_tap

//--- verification/msc_ee_model.sv
// Serial EEPROM stand-in that returns a fixed byte on device reads
`timescale 1ns/1ps
module msc_ee_model #(
  parameter logic [7:0] RX_BYTE = 8'h3c
) (
  // Board side of the EEPROM pins
  input  wire logic ee_clk_i,
  input  wire logic ee_oe_i,
  output logic      ee_io_o
);
  logic [2:0] idx = 3'h7;
  logic       rd_half = 1'b0;
  // Direction caught at the rising clock, where it never moves; the last
  // falling clock of a read also hands the pin back, so it cannot be used
  always @(posedge ee_clk_i) rd_half <= !ee_oe_i;
  // Next bit after each falling clock of a read; the device owns the clock
  always @(negedge ee_clk_i) begin
    if (rd_half) idx <= idx - 3'h1;
  end
  assign ee_io_o = RX_BYTE[idx];
endmodule : msc_ee_model

//--- verification/tb_misc_pin_strap_debug_control.sv
// Register-level testbench of the miscellaneous pin block
`timescale 1ns/1ps
module tb_misc_pin_strap_debug_control;
  logic clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 0, gpio_i = 0, gpio_o, gpio_oe_o;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o, rd;
  logic smbus_used_i = 0, power_save_strap_i = 1;
  logic debug_mode_enable_pin_i = 1, status_output_enable_pin_i = 0;
  logic mfg_test_i = 0, scan_drv = 0, scan_en_i, scan_en_o, scan_en_oe_o;
  logic [2:0] port_state_i = 0, smb_address_o, port_status_o;
  logic [4:0] debug_select_o;
  logic debug_mode_o, power_save_o, port_status_oe_o, ee_pad;
  logic eeprom_serial_clock_o, eeprom_serial_io_i, eeprom_serial_io_o;
  logic eeprom_serial_io_oe_o, tck_i = 0, tms_i = 0, tdi_i = 0;
  logic trst_n_i = 0, tdo_o, tdo_oe_o;
  int errors = 0, comparisons = 0;
  time t_rise = 0;
  always #5 clk_i = ~clk_i;
  // Pin levels resolved from whoever drives them
  assign scan_en_i = scan_en_oe_o ? scan_en_o : scan_drv;
  assign eeprom_serial_io_i = eeprom_serial_io_oe_o ? eeprom_serial_io_o
                                                    : ee_pad;
  msc_misc_pins dut_u (.clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .smbus_used_i, .port_state_i,
    .smb_address_o, .debug_select_o, .debug_mode_o, .power_save_o, .gpio_i,
    .gpio_o, .gpio_oe_o, .power_save_strap_i, .debug_mode_enable_pin_i,
    .status_output_enable_pin_i, .mfg_test_i, .port_status_o,
    .port_status_oe_o, .scan_en_i, .scan_en_o, .scan_en_oe_o,
    .eeprom_serial_clock_o, .eeprom_serial_io_i, .eeprom_serial_io_o,
    .eeprom_serial_io_oe_o, .tck_i, .tms_i, .tdi_i, .trst_n_i, .tdo_o,
    .tdo_oe_o);
  msc_ee_model #(.RX_BYTE(8'h3c)) ee_u (.ee_clk_i(eeprom_serial_clock_o),
    .ee_oe_i(eeprom_serial_io_oe_o), .ee_io_o(ee_pad));
  // Compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt
  // Register bus cycles: one-cycle strobes, read data the cycle after
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, rd);
    chk(rd, e);
  endtask : rd_chk
  // Strap levels set up before and across the reset release
  task automatic do_reset(input logic ps, input logic dbg_n);
    @(posedge clk_i);
    nrst_i <= 1'b0; power_save_strap_i <= ps; debug_mode_enable_pin_i <= dbg_n;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    wt(8);
  endtask : do_reset
  // One test clock period, slow enough for the pin synchronisers
  task automatic tck_cyc(input logic m, input logic d);
    @(posedge clk_i);
    tms_i <= m; tdi_i <= d; tck_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    tck_i <= 1'b1;
    wt(8);
  endtask : tck_cyc
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    give_verdict();
  end
  initial begin
    do_reset(1'b1, 1'b1);
    chk(scan_en_o, 0); chk(scan_en_oe_o, 1);
    chk(eeprom_serial_io_o, 1);
    rd_chk(8'h14, 32'hff);
    rd_chk(8'h00, 0);
    gpio_i <= 8'hb6; power_save_strap_i <= 1'b0;
    wr_reg(8'h00, 32'hff);
    wr_reg(8'h04, 32'ha5);
    wt(4);
    chk(gpio_oe_o, 8'hff); chk(gpio_o, 8'ha5);
    rd_chk(8'h08, 32'hb6);
    rd_chk(8'h40, 0);
    smbus_used_i <= 1'b1;
    wt(4);
    chk(gpio_oe_o, 8'h1f); chk(smb_address_o, 3'h5);
    chk(power_save_o, 1); chk(debug_mode_o, 0);
    rd_chk(8'h0c, 32'h51);
    // EEPROM write of 96, most significant bit first
    wr_reg(8'h14, 32'h96);
    wr_reg(8'h10, 32'h1);
    rd_chk(8'h10, 32'h4);
    // Bit period is two half periods of EE_HALF_CYC cycles of the 10 ns system clock
    for (int i = 7; i >= 0; i--) begin
      @(posedge eeprom_serial_clock_o);
      if (i < 7) chk(32'($time - t_rise),
                     32'(20 * msc_pkg::EE_HALF_CYC));
      t_rise = $time;
      chk(eeprom_serial_io_o, 8'h96 >> i & 1);
      chk(eeprom_serial_io_oe_o, 1);
    end
    wt(600);
    rd_chk(8'h10, 0);
    chk(eeprom_serial_io_o, 1);
    chk(eeprom_serial_clock_o, 0);
    wr_reg(8'h10, 32'h3);
    rd_chk(8'h10, 32'h6);
    wt(4000);
    chk(eeprom_serial_io_oe_o, 0);
    wt(4600);
    rd_chk(8'h14, 32'h3c);
    // Debug mode entered by a reset with the enable pin low
    smbus_used_i <= 1'b0; port_state_i <= 3'h5;
    do_reset(1'b0, 1'b0);
    chk(debug_mode_o, 1); chk(power_save_o, 0);
    chk(debug_select_o, 5'h16);
    wr_reg(8'h00, 32'hff);
    status_output_enable_pin_i <= 1'b1;
    wt(6);
    chk(gpio_oe_o, 8'he0);
    chk(port_status_oe_o, 1); chk(port_status_o, 3'h5);
    status_output_enable_pin_i <= 1'b0;
    wt(6);
    chk(port_status_oe_o, 0); chk(port_status_o, 0);
    // Test port: bypass shifting with the scan pin released to the tester
    mfg_test_i <= 1'b1; scan_drv <= 1'b1; trst_n_i <= 1'b1;
    wt(4);
    chk(scan_en_oe_o, 0);
    for (int i = 0; i < 9; i++) tck_cyc(i < 5 || i == 6, 1'b0);
    for (int i = 0; i < 4; i++) tck_cyc(1'b0, 1'b1);
    chk(tdo_oe_o, 1); chk(tdo_o, 1);
    for (int i = 0; i < 4; i++) tck_cyc(1'b0, 1'b0);
    chk(tdo_o, 0);
    trst_n_i <= 1'b0;
    wt(10);
    chk(tdo_oe_o, 0);
    // Instruction path: captured value leaves first, shifted bit follows
    trst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) tck_cyc(i == 1 || i == 2, 1'b0);
    tck_cyc(1'b0, 1'b1);
    chk(tdo_oe_o, 1); chk(tdo_o, 1);
    for (int i = 0; i < 4; i++) tck_cyc(1'b0, 1'b0);
    chk(tdo_o, 1);
    give_verdict();
  end
endmodule : tb_misc_pin_strap_debug_control
